// *** timer_cfg.svh ***
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_IRQ_FLAGS_ENABLES 16'h106b
`define IDX_MODE_EDGE_CONTROL 16'h106c
`define IDX_EVENT_PIN_CONTROL 16'h106d
`define IDX_CAPTURE_PINS_CTRL 16'h106e
`define ADDR_WIDTH            16

// Interrupt flag and enable register fields
`define CMP_ONE_IRQ_ENABLE_BIT 0
`define CMP_TWO_IRQ_ENABLE_BIT 1
`define EDGE_ONE_IRQ_ENABLE_BIT 2
`define CMP_ONE_IRQ_FLAG_BIT   5
`define CMP_TWO_IRQ_FLAG_BIT   6
`define EDGE_ONE_IRQ_FLAG_BIT  7

// Mode and edge control register fields
`define EDGE_ONE_ARM_BIT       0
`define SHARED_BIT1            1
`define EDGE_ONE_RISING_BIT    2
`define SHARED_BIT3            3
`define CMP_ONE_CLEAR_EN_BIT   4
`define CMP_TWO_TOGGLE_EN_BIT  5
`define CMP_ONE_TOGGLE_EN_BIT  6
`define CAPTURE_MODE_SEL_BIT   7

// Pin control nibble fields (low nibble; high nibble adds 4)
`define PIN_DIR_BIT            0
`define PIN_FUNC_BIT           1
`define PIN_OUT_BIT            2
`define PIN_IN_BIT             3

`define REG_RESET              8'h00
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

// *** timer_pkg.sv ***
package timer_pkg;
   typedef enum logic {
      DUAL_COMPARE,
      DUAL_CAPTURE
   } timer_mode_t;

   // One pin as driven by the block; enableN low while driving
   typedef struct packed {
      logic level;
      logic enableN;
   } pin_drive_t;

   // Pulses handed to the counter and capture registers
   typedef struct packed {
      logic counterClear;
      logic captureOneLoad;
      logic captureTwoLoad;
   } timer_events_t;
endpackage

// *** timer_compare_capture_ctrl.sv ***
// Summary of operation
// - Control register three bit 7 picks dual compare (0) or dual capture (1).
// - Compare-one match sets flag bit 5; written zero or reset clears it.
// - Dual compare: compare-two match sets flag bit 6; zero write clears.
// - Dual capture: selected edge on pin two sets flag bit 6, capture loaded.
// - Selected edge on pin one sets flag bit 7; zero write clears.
// - Compare-one interrupts need enable bit 0; compare-two needs bit 1.
// - Edge-one interrupts need enable bit 2; edge-two needs bit 1 in capture.
// - Bits 3 and 4 of the flag register are unimplemented.
// - Arm bit 0 senses next edge on pin one; hardware clears it after.
// - Capture mode: bit 1 arms pin two; hardware clears it after the edge.
// - Compare mode: bit 1 lets an edge on pin one clear the counter.
// - Bit 2 picks pin one edge: 0 falling, 1 rising.
// - Compare mode: bit 3 lets the edge-one pulse toggle the output pin.
// - Capture mode: bit 3 picks pin two edge: 0 falling, 1 rising.
// - Bit 4 lets a compare-one match clear the counter at next increment.
// - Compare mode: bit 5 lets compare-two match toggle the output pin.
// - Compare mode: bit 6 lets compare-one match toggle the output pin.
// - Each pin gets a four-bit control group in a port control register.
//
// Chosen here: the AXI4-Lite interface to the registers.
`include "timer_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module timer_compare_capture_ctrl (
   input  wire logic                        clk,
   input  wire logic                        rstn,
   // AXI4-Lite slave
   input  wire logic [`ADDR_WIDTH-1:0]      s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [`ADDR_WIDTH-1:0]      s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // Counter side
   input  wire logic                        cmpOneEqual,
   input  wire logic                        cmpTwoEqual,
   output timer_pkg::timer_events_t         timerEvents,
   output logic                             eventInput,
   output logic                             timerIrq,
   // Pins
   input  wire logic                        captureResetPinIn,
   output timer_pkg::pin_drive_t            captureResetPinDrive,
   input  wire logic                        captureWavePinIn,
   output timer_pkg::pin_drive_t            captureWavePinDrive,
   input  wire logic                        eventInputPinIn,
   output timer_pkg::pin_drive_t            eventInputPinDrive
);
   import timer_pkg::*;

   localparam logic [`ADDR_WIDTH-1:0] ADDR_FLAGS = `ADDR_WIDTH'(`IDX_IRQ_FLAGS_ENABLES * 4);
   localparam logic [`ADDR_WIDTH-1:0] ADDR_MODE  = `ADDR_WIDTH'(`IDX_MODE_EDGE_CONTROL * 4);
   localparam logic [`ADDR_WIDTH-1:0] ADDR_EVPC  = `ADDR_WIDTH'(`IDX_EVENT_PIN_CONTROL * 4);
   localparam logic [`ADDR_WIDTH-1:0] ADDR_CPPC  = `ADDR_WIDTH'(`IDX_CAPTURE_PINS_CTRL * 4);

   logic [7:0]             irqFlagsEnables;
   logic [7:0]             modeEdgeControl;
   logic [3:0]             eventPinControl;
   logic [7:0]             capturePinsControl;
   logic                   awHeld;
   logic                   wHeld;
   logic [`ADDR_WIDTH-1:0] awAddr;
   logic [7:0]             wByte;
   logic                   wLane;
   logic                   doWrite;
   logic                   resetPinLast;
   logic                   wavePinLast;
   logic                   edgeOneSeen;
   logic                   edgeTwoSeen;
   logic                   waveLevel;
   logic                   writeFlags;
   logic                   writeMode;
   timer_mode_t            mode;
   logic [7:0]             readValue;
   logic                   readHit;

   assign mode = modeEdgeControl[`CAPTURE_MODE_SEL_BIT] ? DUAL_CAPTURE : DUAL_COMPARE;

   // Write channel: address and data are taken in either order, then answered
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld && !s_axi_bvalid;
   assign doWrite       = awHeld && wHeld && !s_axi_bvalid;
   assign writeFlags    = doWrite && wLane && awAddr == ADDR_FLAGS;
   assign writeMode     = doWrite && wLane && awAddr == ADDR_MODE;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         awHeld <= 1'b0;
         awAddr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld <= 1'b1;
         awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wHeld <= 1'b0;
         wByte <= 8'h00;
         wLane <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld <= 1'b1;
         wByte <= s_axi_wdata[7:0];
         wLane <= s_axi_wstrb[0];
      end else if (doWrite) begin
         wHeld <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awAddr == ADDR_FLAGS || awAddr == ADDR_MODE ||
                          awAddr == ADDR_EVPC || awAddr == ADDR_CPPC) ?
                         `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Edge detection; pins are taken as synchronous already
   always_ff @(posedge clk) begin
      if (!rstn) begin
         // Pins idle high, so a low history would fake a rising edge
         resetPinLast <= 1'b1;
         wavePinLast  <= 1'b1;
      end else begin
         resetPinLast <= captureResetPinIn;
         wavePinLast  <= captureWavePinIn;
      end
   end

   always_comb begin
      edgeOneSeen = 1'b0;
      edgeTwoSeen = 1'b0;
      // Edge logic only listens while the pin is in its timer function
      if (modeEdgeControl[`EDGE_ONE_ARM_BIT] &&
          capturePinsControl[`PIN_FUNC_BIT]) begin
         if (modeEdgeControl[`EDGE_ONE_RISING_BIT]) begin
            edgeOneSeen = captureResetPinIn && !resetPinLast;
         end else begin
            edgeOneSeen = !captureResetPinIn && resetPinLast;
         end
      end
      if (mode == DUAL_CAPTURE && modeEdgeControl[`SHARED_BIT1] &&
          capturePinsControl[`PIN_FUNC_BIT + 4]) begin
         if (modeEdgeControl[`SHARED_BIT3]) begin
            edgeTwoSeen = captureWavePinIn && !wavePinLast;
         end else begin
            edgeTwoSeen = !captureWavePinIn && wavePinLast;
         end
      end
   end

   // Flags: a hardware set in the cycle of a zero write wins
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irqFlagsEnables <= `REG_RESET;
      end else begin
         if (writeFlags) begin
            irqFlagsEnables[2:0] <= wByte[2:0];
            irqFlagsEnables[7:5] <= irqFlagsEnables[7:5] & wByte[7:5];
         end
         if (cmpOneEqual) begin
            irqFlagsEnables[`CMP_ONE_IRQ_FLAG_BIT] <= 1'b1;
         end
         if ((mode == DUAL_COMPARE && cmpTwoEqual) || edgeTwoSeen) begin
            irqFlagsEnables[`CMP_TWO_IRQ_FLAG_BIT] <= 1'b1;
         end
         if (edgeOneSeen) begin
            irqFlagsEnables[`EDGE_ONE_IRQ_FLAG_BIT] <= 1'b1;
         end
         irqFlagsEnables[4:3] <= 2'h0;
      end
   end

   // Arm bits drop when their edge is seen, even against a write of one
   always_ff @(posedge clk) begin
      if (!rstn) begin
         modeEdgeControl <= `REG_RESET;
      end else begin
         if (writeMode) begin
            modeEdgeControl <= wByte;
         end
         if (edgeOneSeen) begin
            modeEdgeControl[`EDGE_ONE_ARM_BIT] <= 1'b0;
         end
         if (edgeTwoSeen) begin
            modeEdgeControl[`SHARED_BIT1] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         eventPinControl    <= 4'h0;
         capturePinsControl <= `REG_RESET;
      end else if (doWrite && wLane) begin
         if (awAddr == ADDR_EVPC) begin
            eventPinControl <= wByte[3:0];
         end
         if (awAddr == ADDR_CPPC) begin
            capturePinsControl <= wByte;
         end
      end
   end

   // Counter clear and capture strobes, one cycle after their cause
   always_ff @(posedge clk) begin
      if (!rstn) begin
         timerEvents <= '0;
      end else begin
         timerEvents.counterClear <=
            (cmpOneEqual && modeEdgeControl[`CMP_ONE_CLEAR_EN_BIT]) ||
            (mode == DUAL_COMPARE && edgeOneSeen &&
             modeEdgeControl[`SHARED_BIT1]);
         timerEvents.captureOneLoad <= edgeOneSeen;
         timerEvents.captureTwoLoad <= edgeTwoSeen;
      end
   end

   // Waveform output toggles only in compare mode
   always_ff @(posedge clk) begin
      if (!rstn) begin
         waveLevel <= 1'b0;
      end else if (mode == DUAL_COMPARE) begin
         waveLevel <= waveLevel ^
            ((edgeOneSeen && modeEdgeControl[`SHARED_BIT3]) ^
             (cmpTwoEqual && modeEdgeControl[`CMP_TWO_TOGGLE_EN_BIT]) ^
             (cmpOneEqual && modeEdgeControl[`CMP_ONE_TOGGLE_EN_BIT]));
      end
   end

   assign timerIrq =
      (irqFlagsEnables[`CMP_ONE_IRQ_FLAG_BIT] && irqFlagsEnables[`CMP_ONE_IRQ_ENABLE_BIT]) ||
      (irqFlagsEnables[`CMP_TWO_IRQ_FLAG_BIT] && irqFlagsEnables[`CMP_TWO_IRQ_ENABLE_BIT]) ||
      (irqFlagsEnables[`EDGE_ONE_IRQ_FLAG_BIT] && irqFlagsEnables[`EDGE_ONE_IRQ_ENABLE_BIT]);

   // Pin drivers: timer function overrides general-purpose I/O
   always_comb begin
      captureResetPinDrive.level   = capturePinsControl[`PIN_OUT_BIT];
      captureResetPinDrive.enableN = !(capturePinsControl[`PIN_DIR_BIT] &&
                                       !capturePinsControl[`PIN_FUNC_BIT]);
      if (capturePinsControl[`PIN_FUNC_BIT + 4]) begin
         captureWavePinDrive.level   = waveLevel;
         captureWavePinDrive.enableN = mode == DUAL_CAPTURE;
      end else begin
         captureWavePinDrive.level   = capturePinsControl[`PIN_OUT_BIT + 4];
         captureWavePinDrive.enableN = !capturePinsControl[`PIN_DIR_BIT + 4];
      end
      eventInputPinDrive.level   = eventPinControl[`PIN_OUT_BIT];
      eventInputPinDrive.enableN = !(eventPinControl[`PIN_DIR_BIT] &&
                                     !eventPinControl[`PIN_FUNC_BIT]);
   end

   assign eventInput = eventPinControl[`PIN_FUNC_BIT] && eventInputPinIn;

   // Read mux; undefined bits read as zero
   always_comb begin
      readValue = 8'h00;
      readHit   = 1'b1;
      case (s_axi_araddr)
         ADDR_FLAGS: begin
            readValue = irqFlagsEnables;
         end
         ADDR_MODE: begin
            readValue = modeEdgeControl;
            if (mode == DUAL_CAPTURE) begin
               readValue[6:5] = 2'h0;
            end
         end
         ADDR_EVPC: begin
            readValue = {4'h0, eventInputPinIn, eventPinControl[2:0]};
         end
         ADDR_CPPC: begin
            readValue = {captureWavePinIn, capturePinsControl[6:4],
                         captureResetPinIn, capturePinsControl[2:0]};
         end
         default: begin
            readHit = 1'b0;
         end
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, readValue};
         s_axi_rresp  <= readHit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

`default_nettype wire

// *** timer_ctrl_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module timer_ctrl_assertions (
   input wire logic                     clk,
   input wire logic                     rstn,
   input wire logic                     s_axi_awvalid,
   input wire logic                     s_axi_awready,
   input wire logic                     s_axi_wvalid,
   input wire logic                     s_axi_wready,
   input wire logic                     s_axi_bvalid,
   input wire logic                     s_axi_bready,
   input wire logic                     s_axi_arvalid,
   input wire logic                     s_axi_arready,
   input wire logic [31:0]              s_axi_rdata,
   input wire logic                     s_axi_rvalid,
   input wire logic                     s_axi_rready,
   input wire timer_pkg::timer_events_t timerEvents,
   input wire logic                     timerIrq
);
   import timer_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_wr_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late or wide");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data moved while held");
   property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_busy: assert property (p_busy) else $error("write taken while answer pending");
   // Arm is dropped by the detect, so a load never lasts two cycles
   property p_load_one; timerEvents.captureOneLoad |=> !timerEvents.captureOneLoad; endproperty
   a_load_one: assert property (p_load_one) else $error("edge one fired twice");
   property p_load_two; timerEvents.captureTwoLoad |=> !timerEvents.captureTwoLoad; endproperty
   a_load_two: assert property (p_load_two) else $error("edge two fired twice");
   property p_reset;
      disable iff (1'b0) !rstn |=> !timerIrq && timerEvents == 3'h0 && !s_axi_bvalid;
   endproperty
   a_reset: assert property (p_reset) else $error("reset left state");
endmodule
`default_nettype wire

// *** pin_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
   input  wire timer_pkg::pin_drive_t resetDrive,
   input  wire timer_pkg::pin_drive_t waveDrive,
   input  wire timer_pkg::pin_drive_t eventDrive,
   output logic                       resetPin,
   output logic                       wavePin,
   output logic                       eventPin
);
   import timer_pkg::*;
   // Outside sources idle high, as through pull-ups
   logic [2:0] ext = 3'h7;
   // Block wins the wire only while its enable is low
   assign resetPin = resetDrive.enableN ? ext[0] : resetDrive.level;
   assign wavePin  = waveDrive.enableN ? ext[1] : waveDrive.level;
   assign eventPin = eventDrive.enableN ? ext[2] : eventDrive.level;
   task automatic drive(input int sel, input logic lvl);
      ext[sel] <= lvl;
   endtask
endmodule
`default_nettype wire

// *** timer_compare_capture_ctrl_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "timer_cfg.svh"
module timer_compare_capture_ctrl_tb;
   import timer_pkg::*;
   localparam logic [15:0] FL = `IDX_IRQ_FLAGS_ENABLES;
   localparam logic [15:0] MD = `IDX_MODE_EDGE_CONTROL;
   localparam logic [15:0] EP = `IDX_EVENT_PIN_CONTROL;
   localparam logic [15:0] PC = `IDX_CAPTURE_PINS_CTRL;
   logic          clk = 1'b0, rstn = 1'b0, wv = 1'b0, c1 = 1'b0, c2 = 1'b0;
   logic          aw = 1'b0, w = 1'b0, bready = 1'b0, ar = 1'b0, rready = 1'b0;
   logic [15:0]   awaddr = 16'h0000, araddr = 16'h0000;
   logic [31:0]   wdata = 32'h0000_0000;
   logic          awready, wready, bvalid, arready, rvalid, irq, evIn, pOne, pTwo, pEvt;
   logic [1:0]    bresp, rresp;
   logic [31:0]   rdata;
   timer_events_t ev;
   pin_drive_t    dOne, dTwo, dEvt;
   logic [7:0]    mv [3] = '{8'h10, 8'h40, 8'h20};
   int            err_total = 0, checked = 0, cyc = 0;
   initial forever #20 clk = ~clk;
   timer_compare_capture_ctrl timer_compare_capture_ctrl_i (
      .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(aw),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(w),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(ar),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmpOneEqual(c1), .cmpTwoEqual(c2),
      .timerEvents(ev), .eventInput(evIn), .timerIrq(irq), .captureResetPinIn(pOne),
      .captureResetPinDrive(dOne), .captureWavePinIn(pTwo), .captureWavePinDrive(dTwo),
      .eventInputPinIn(pEvt), .eventInputPinDrive(dEvt)
   );
   pin_partner pin_partner_i (
      .resetDrive(dOne), .waveDrive(dTwo), .eventDrive(dEvt),
      .resetPin(pOne), .wavePin(pTwo), .eventPin(pEvt)
   );
   task automatic give_verdict();
      if (err_total == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic wrt, input logic [15:0] idx, input logic [7:0] d);
      logic a, b, r;
      logic [1:0] er;
      er = (idx inside {FL, MD, EP, PC}) ? 2'h0 : 2'h2;
      awaddr <= idx << 2;
      araddr <= idx << 2;
      wdata  <= {24'h0, d};
      aw     <= wrt;
      w      <= wrt;
      ar     <= ~wrt;
      bready <= wrt;
      rready <= ~wrt;
      do begin
         // Sampled mid-cycle so ready has settled before the taking edge
         @(negedge clk);
         a = wrt ? awready & aw : arready & ar;
         b = wready & w;
         r = wrt ? bvalid : rvalid;
         if (r) chk({wrt ? bresp : rresp, wrt ? 8'h00 : rdata[7:0]}, {er, wrt ? 8'h00 : d});
         @(posedge clk);
         if (a && wrt) aw <= 1'b0;
         if (a && !wrt) ar <= 1'b0;
         if (b) w <= 1'b0;
      end while (!r);
      bready <= 1'b0;
      rready <= 1'b0;
      // Idle cycle so the next call never re-drives a signal in this time step
      @(posedge clk);
   endtask
   // Pin edge and compare pulse launch together; results land one edge later
   task automatic step(input logic [1:0] cm, input int sel, input logic lvl,
                       input logic [2:0] exp);
      c1 <= cm[1];
      c2 <= cm[0];
      if (sel >= 0) pin_partner_i.drive(sel, lvl);
      @(posedge clk);
      c1 <= 1'b0;
      c2 <= 1'b0;
      @(negedge clk);
      chk({ev.counterClear, ev.captureTwoLoad, dTwo.level}, exp);
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      acc(0, FL, 8'h00);
      acc(0, MD, 8'h00);
      acc(0, 16'h106a, 8'h00);
      acc(1, 16'h106a, 8'hff);
      acc(1, PC, 8'h22);
      step(2'b10, -1, 1'b0, 3'h0);
      acc(0, FL, 8'h20);
      chk(irq, 1'b0);
      acc(1, FL, 8'hff);
      acc(0, FL, 8'h27);
      chk(irq, 1'b1);
      step(2'b01, -1, 1'b0, 3'h0);
      acc(0, FL, 8'h67);
      acc(1, FL, 8'h47);
      acc(0, FL, 8'h47);
      acc(1, FL, 8'h05);
      chk(irq, 1'b0);
      foreach (mv[k]) begin
         acc(1, MD, mv[k]);
         for (int j = 1; j < 3; j++) begin
            wv = wv ^ (mv[k][6] & j[1]) ^ (mv[k][5] & j[0]);
            step(j[1:0], -1, 1'b0, {mv[k][4] & j[1], 1'b0, wv});
         end
      end
      for (int p = 0; p < 2; p++) begin
         acc(1, FL, 8'h05);
         step(2'b00, 0, p[0], {2'b00, wv});
         acc(1, MD, {4'h0, 1'b1, p[0], p[0], 1'b1});
         step(2'b00, 0, ~p[0], {2'b00, wv});
         wv = ~wv;
         step(2'b00, 0, p[0], {p[0], 1'b0, wv});
         acc(0, MD, {4'h0, 1'b1, p[0], p[0], 1'b0});
         acc(0, FL, 8'h85);
         chk(irq, 1'b1);
         step(2'b00, 0, ~p[0], {2'b00, wv});
         step(2'b00, 0, p[0], {2'b00, wv});
      end
      for (int p = 0; p < 2; p++) begin
         acc(1, FL, {5'h00, 1'b1, p[0], 1'b1});
         acc(1, MD, {4'h8, p[0], 3'h0});
         step(2'b00, 1, p[0], {2'b00, wv});
         acc(1, MD, {4'he, p[0], 3'h2});
         step(2'b00, 1, ~p[0], {2'b00, wv});
         step(2'b00, 1, p[0], {2'b01, wv});
         acc(0, MD, {4'h8, p[0], 3'h0});
         acc(0, FL, {5'h08, 1'b1, p[0], 1'b1});
         chk(irq, p[0]);
      end
      acc(1, EP, 8'h02);
      chk(evIn, 1'b1);
      step(2'b00, 2, 1'b0, {2'b00, wv});
      chk(evIn, 1'b0);
      acc(1, EP, 8'h05);
      chk({dEvt.level, dEvt.enableN}, 2'b10);
      acc(0, EP, 8'h0d);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      acc(0, FL, 8'h00);
      acc(0, MD, 8'h00);
      give_verdict();
   end
endmodule
bind timer_compare_capture_ctrl timer_ctrl_assertions timer_ctrl_assertions_i (
   .clk(clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .timerEvents(timerEvents), .timerIrq(timerIrq)
);
`default_nettype wire
